// ---- wl_pkg.sv ----
// Function
// - Leveling enable bit enters and leaves leveling
// - Termination pin steers strobe termination only
// - Nominal-high or park-low turns strobe termination on
// - Termination values restricted unless outputs disabled; outputs stay on, so termFault is set
// - Controller disables outputs of other ranks; this controller writes only its own rank
// - Data pins undefined until feedback starts
// - Only deselect and two mode writes allowed
// - Exit write may update listed mode bits
// - Termination pin used only after mode delay
// - Strobe termination ready by strobe enable delay
// - One strobe edge after low width, first delay
// - Rising strobe samples clock, drives all data
// - No read strobe driven with feedback
// - Controller steps delay, locks on rising feedback
// - Each byte lane reports its own strobe
// - Strobe pulses keep normal write widths
// - Exit: stop strobes, termination low, mode write
// - Wait mode delays after exit write
package wl_pkg;
    localparam int CLK_NS = 10;
    localparam int MOD_NS = 240;
    localparam int MRD_NS = 80;
    localparam int STB_EN_NS = 250;
    localparam int FIRST_NS = 400;
    localparam int ODT_OFF_NS = 100;
    localparam int FBO_NS = 20;
    localparam logic [7:0] MOD_CYC = 8'((MOD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] MRD_CYC = 8'((MRD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] STB_EN_CYC = 8'((STB_EN_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] FIRST_CYC = 8'((FIRST_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] ODT_OFF_CYC = 8'((ODT_OFF_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] FBO_CYC = 8'(FBO_NS / CLK_NS);
    localparam int BIT_LVL = 7;
    localparam int BIT_QOFF = 12;
    localparam int NOM_LO = 8;
    localparam int NOM_HI = 10;
    localparam logic [1:0] CMD_DESEL = 2'h0;
    localparam logic [1:0] CMD_MODE = 2'h1;
    localparam logic [1:0] CMD_OTHER = 2'h2;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RESULT = 8'h08;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        D_IDLE = 3'b001,
        D_LEVEL = 3'b010,
        D_EXITW = 3'b100
    } wl_dev_st_e;
    typedef enum logic [8:0] {
        C_IDLE = 9'h001,
        C_MODWT = 9'h002,
        C_ENWT = 9'h004,
        C_FSTWT = 9'h008,
        C_ROUND = 9'h010,
        C_FBWT = 9'h020,
        C_EXODT = 9'h040,
        C_EXMR = 9'h080,
        C_EXWT = 9'h100
    } wl_ctl_st_e;
endpackage : wl_pkg

// ---- wl_link_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface wl_link_if #(parameter int LANES = 2, parameter int LW = 8);
    logic [1:0]          cmd;
    logic [12:0]         cmdAddr;
    logic                termination_control_pin;
    logic                memCk;
    logic [LANES-1:0]    ctlStb;
    logic                ctlStbOe_n;
    logic [LANES-1:0]    devStb;
    logic                devStbOe_n;
    logic [LANES*LW-1:0] ctlDq;
    logic                ctlDqOe_n;
    logic [LANES*LW-1:0] devDq;
    logic                devDqOe_n;
    logic [LANES-1:0]    stb;
    logic [LANES*LW-1:0] dq;
    // Undriven lines settle low through termination
    assign stb = !ctlStbOe_n ? ctlStb : (!devStbOe_n ? devStb : '0);
    assign dq = !devDqOe_n ? devDq : (!ctlDqOe_n ? ctlDq : '0);
    modport ctl (output cmd, cmdAddr, termination_control_pin, memCk, ctlStb, ctlStbOe_n, ctlDq,
                 ctlDqOe_n, input stb, dq);
    modport dev (input cmd, cmdAddr, termination_control_pin, memCk, stb, dq, output devStb,
                 devStbOe_n, devDq, devDqOe_n);
endinterface : wl_link_if
`default_nettype wire

// ---- wl_dev_end.sv ----
`timescale 1ns/1ns
`default_nettype none
module wl_dev_end #(
    parameter int LANES = 2,
    parameter int LW = 8
) (
    input  wire logic       ref_clk,       // Command clock
    input  wire logic       srst,          // Sync reset
    wl_link_if.dev          lnk,           // Link to controller
    input  wire logic [2:0] parkCode,      // Park termination setting
    output logic            levelActive,   // Leveling mode on
    output logic            strobeTermOn,  // Strobe termination on
    output logic            dqTermOn,      // Data termination on
    output logic            fbValid,       // Feedback on data pins
    output logic            cmdFault,      // Illegal command seen
    output logic            termFault      // Disallowed termination
);
    typedef struct packed {
        wl_pkg::wl_dev_st_e st;
        logic [12:0]        mr1;
        logic [7:0]         cnt;
        logic               odtOk;
        logic [LANES-1:0]   stbPrev;
        logic [LANES-1:0]   fb;
        logic               fbOn;
        logic               dqOe_n;
        logic               sTerm;
        logic               dTerm;
        logic               cmdFault;
        logic               termFault;
    } wl_dev_s;

    wl_dev_s q_ff;
    wl_dev_s nxt_q;
    logic    nomOn;
    logic    parkOn;
    logic    odtEff;
    logic    normTerm;

    if (LANES < 1 || LANES > 2 || LW < 1)
    begin : g_bad_lanes
        $error("Lane layout not supported");
    end

    always_comb
    begin
        nxt_q = q_ff;
        nomOn = |q_ff.mr1[wl_pkg::NOM_HI:wl_pkg::NOM_LO];
        parkOn = |parkCode;
        odtEff = lnk.termination_control_pin & q_ff.odtOk;
        normTerm = (nomOn & lnk.termination_control_pin) | (parkOn & ~lnk.termination_control_pin);
        nxt_q.stbPrev = lnk.stb;
        unique case (q_ff.st)
            wl_pkg::D_IDLE:
            begin
                if (lnk.cmd == wl_pkg::CMD_MODE)
                begin
                    nxt_q.mr1 = lnk.cmdAddr;
                    if (lnk.cmdAddr[wl_pkg::BIT_LVL])
                    begin
                        nxt_q.st = wl_pkg::D_LEVEL;
                        nxt_q.cnt = wl_pkg::MOD_CYC;
                        nxt_q.odtOk = 1'b0;
                        nxt_q.fbOn = 1'b0;
                    end
                end
            end
            wl_pkg::D_LEVEL:
            begin
                if (q_ff.cnt != 8'h00)
                    nxt_q.cnt = q_ff.cnt - 8'h01;
                else
                    nxt_q.odtOk = 1'b1;
                // Clock level caught per lane on its own strobe
                for (int l = 0; l < LANES; l++)
                begin
                    if (lnk.stb[l] && !q_ff.stbPrev[l])
                    begin
                        nxt_q.fb[l] = lnk.memCk;
                        nxt_q.fbOn = 1'b1;
                    end
                end
                if (lnk.cmd == wl_pkg::CMD_MODE)
                begin
                    if (!lnk.cmdAddr[wl_pkg::BIT_LVL])
                    begin
                        nxt_q.mr1[12:8] = lnk.cmdAddr[12:8];
                        nxt_q.mr1[2:1] = lnk.cmdAddr[2:1];
                        nxt_q.mr1[wl_pkg::BIT_LVL] = 1'b0;
                        nxt_q.st = wl_pkg::D_EXITW;
                        nxt_q.cnt = wl_pkg::MOD_CYC;
                        nxt_q.fbOn = 1'b0;
                    end
                    else
                        nxt_q.mr1[wl_pkg::BIT_QOFF] = lnk.cmdAddr[wl_pkg::BIT_QOFF];
                end
                else if (lnk.cmd == wl_pkg::CMD_OTHER)
                    nxt_q.cmdFault = 1'b1;
            end
            wl_pkg::D_EXITW:
            begin
                nxt_q.cnt = q_ff.cnt - 8'h01;
                // Mode writes allowed after the shorter delay only
                if (lnk.cmd == wl_pkg::CMD_OTHER)
                    nxt_q.cmdFault = 1'b1;
                else if (lnk.cmd == wl_pkg::CMD_MODE)
                begin
                    if (q_ff.cnt > wl_pkg::MOD_CYC - wl_pkg::MRD_CYC)
                        nxt_q.cmdFault = 1'b1;
                    nxt_q.mr1 = lnk.cmdAddr;
                end
                if (q_ff.cnt == 8'h01)
                    nxt_q.st = wl_pkg::D_IDLE;
            end
            default:
                nxt_q.st = wl_pkg::D_IDLE;
        endcase
        if (nxt_q.st == wl_pkg::D_LEVEL)
        begin
            nxt_q.sTerm = (nomOn & odtEff) | (parkOn & ~odtEff);
            nxt_q.dTerm = 1'b0;
            nxt_q.termFault = ~q_ff.mr1[wl_pkg::BIT_QOFF] & (nomOn | parkOn);
        end
        else
        begin
            nxt_q.sTerm = normTerm;
            nxt_q.dTerm = normTerm;
            nxt_q.termFault = 1'b0;
        end
        // Undefined value driven from entry until exit delay ends
        nxt_q.dqOe_n = (nxt_q.st == wl_pkg::D_IDLE) | nxt_q.mr1[wl_pkg::BIT_QOFF];
        if (nxt_q.st != wl_pkg::D_LEVEL)
            nxt_q.fb = '0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            q_ff <= '{st: wl_pkg::D_IDLE, dqOe_n: 1'b1, default: '0};
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    for (genvar l = 0; l < LANES; l++)
    begin : g_lane
        assign lnk.devDq[l*LW +: LW] = {LW{q_ff.fb[l]}};
    end
    assign lnk.devDqOe_n = q_ff.dqOe_n;
    assign lnk.devStb = '0;
    assign lnk.devStbOe_n = 1'b1;
    // One-hot state: bit 1 is the leveling state, so no decode after the flop
    assign levelActive = q_ff.st[1];
    assign strobeTermOn = q_ff.sTerm;
    assign dqTermOn = q_ff.dTerm;
    assign fbValid = q_ff.fbOn;
    assign cmdFault = q_ff.cmdFault;
    assign termFault = q_ff.termFault;
endmodule : wl_dev_end
`default_nettype wire

// ---- wl_ctl_end.sv ----
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module wl_ctl_end #(
    parameter int LANES = 2,
    parameter int LW = 8,
    parameter int PW = 3,
    parameter int HI_W = 2
) (
    input  wire logic        ref_clk,  // System clock
    input  wire logic        srst,     // Sync reset
    wl_link_if.ctl           lnk,      // Link to device
    input  wire logic [7:0]  awaddr,   // AXI write address
    input  wire logic        awvalid,  // AXI
    output logic             awready,  // AXI
    input  wire logic [31:0] wdata,    // AXI write data
    input  wire logic [3:0]  wstrb,    // AXI byte enables
    input  wire logic        wvalid,   // AXI
    output logic             wready,   // AXI
    output logic [1:0]       bresp,    // AXI
    output logic             bvalid,   // AXI
    input  wire logic        bready,   // AXI
    input  wire logic [7:0]  araddr,   // AXI read address
    input  wire logic        arvalid,  // AXI
    output logic             arready,  // AXI
    output logic [31:0]      rdata,    // AXI read data
    output logic [1:0]       rresp,    // AXI
    output logic             rvalid,   // AXI
    input  wire logic        rready    // AXI
);
    localparam int PER = 2 ** PW;
    typedef struct packed {
        wl_pkg::wl_ctl_st_e   st;
        logic [7:0]           cnt;
        logic [PW-1:0]        ckCnt;
        logic [PW+1:0]        rc;
        logic [1:0]           cmd;
        logic [12:0]          addr;
        logic                 termination_control_pin;
        logic [LANES-1:0]     stb;
        logic                 stbOe_n;
        logic [LANES*PW-1:0]  dly;
        logic [LANES-1:0]     prev;
        logic [LANES-1:0]     lock;
        logic                 seen, busy, done, fail, startReq;
        logic [2:0]           nom;
        logic                 awHeld, wHeld, awready, wready, bvalid, arready, rvalid;
        logic [7:0]           awAddr;
        logic [31:0]          wData;
        logic [3:0]           wStrb;
        logic [1:0]           bresp, rresp;
        logic [31:0]          rdata;
    } wl_ctl_s;

    wl_ctl_s         q_ff;
    wl_ctl_s         nxt_q;
    logic [PW+1:0]   rise;
    logic            fb;

    if (PW < 2 || HI_W < 1 || HI_W >= PER || LANES * PW > 32)
    begin : g_bad_timing
        $error("Strobe timing parameters not supported");
    end

    always_comb
    begin
        nxt_q = q_ff;
        rise = '0;
        fb = 1'b0;
        nxt_q.cmd = wl_pkg::CMD_DESEL;
        nxt_q.ckCnt = q_ff.ckCnt + 1'b1;
        // Register slave: address and data taken in either order
        if (awvalid && q_ff.awready)
        begin
            nxt_q.awHeld = 1'b1;
            nxt_q.awAddr = awaddr;
        end
        if (wvalid && q_ff.wready)
        begin
            nxt_q.wHeld = 1'b1;
            nxt_q.wData = wdata;
            nxt_q.wStrb = wstrb;
        end
        if (q_ff.bvalid && bready)
            nxt_q.bvalid = 1'b0;
        if (q_ff.awHeld && q_ff.wHeld && !q_ff.bvalid)
        begin
            nxt_q.awHeld = 1'b0;
            nxt_q.wHeld = 1'b0;
            nxt_q.bvalid = 1'b1;
            nxt_q.bresp = wl_pkg::RESP_OKAY;
            if (q_ff.awAddr[7:2] != wl_pkg::REG_CTRL[7:2])
                nxt_q.bresp = wl_pkg::RESP_SLVERR;
            else if (q_ff.wStrb[0])
            begin
                nxt_q.nom = q_ff.wData[3:1];
                if (q_ff.wData[0] && !q_ff.busy)
                    nxt_q.startReq = 1'b1;
            end
        end
        nxt_q.awready = !nxt_q.awHeld && !nxt_q.bvalid;
        nxt_q.wready = !nxt_q.wHeld && !nxt_q.bvalid;
        if (q_ff.rvalid && rready)
        begin
            nxt_q.rvalid = 1'b0;
            nxt_q.arready = 1'b1;
        end
        if (arvalid && q_ff.arready)
        begin
            nxt_q.arready = 1'b0;
            nxt_q.rvalid = 1'b1;
            nxt_q.rresp = wl_pkg::RESP_OKAY;
            nxt_q.rdata = '0;
            if (araddr[7:2] == wl_pkg::REG_CTRL[7:2])
                nxt_q.rdata = {28'h0, q_ff.nom, 1'b0};
            else if (araddr[7:2] == wl_pkg::REG_STATUS[7:2])
            begin
                nxt_q.rdata[2:0] = {q_ff.fail, q_ff.done, q_ff.busy};
                nxt_q.rdata[8 +: LANES] = q_ff.lock;
            end
            else if (araddr[7:2] == wl_pkg::REG_RESULT[7:2])
                nxt_q.rdata = 32'(q_ff.dly);
            else
                nxt_q.rresp = wl_pkg::RESP_SLVERR;
        end
        unique case (q_ff.st)
            wl_pkg::C_IDLE:
            begin
                if (q_ff.startReq)
                begin
                    // Own rank enabled with leveling bit and nominal termination; no other rank is written
                    nxt_q.cmd = wl_pkg::CMD_MODE;
                    nxt_q.addr = 13'h0;
                    nxt_q.addr[wl_pkg::BIT_LVL] = 1'b1;
                    nxt_q.addr[wl_pkg::NOM_HI:wl_pkg::NOM_LO] = q_ff.nom;
                    nxt_q.st = wl_pkg::C_MODWT;
                    nxt_q.cnt = wl_pkg::MOD_CYC;
                    nxt_q.startReq = 1'b0;
                    nxt_q.busy = 1'b1;
                    {nxt_q.done, nxt_q.fail, nxt_q.seen} = 3'h0;
                    nxt_q.dly = '0;
                    nxt_q.lock = '0;
                end
            end
            wl_pkg::C_MODWT:
            begin
                nxt_q.cnt = q_ff.cnt - 8'h01;
                if (q_ff.cnt == 8'h01)
                begin
                    nxt_q.termination_control_pin = 1'b1;
                    nxt_q.st = wl_pkg::C_ENWT;
                    nxt_q.cnt = wl_pkg::STB_EN_CYC;
                end
            end
            wl_pkg::C_ENWT:
            begin
                nxt_q.cnt = q_ff.cnt - 8'h01;
                if (q_ff.cnt == 8'h01)
                begin
                    nxt_q.stbOe_n = 1'b0;
                    nxt_q.stb = '0;
                    nxt_q.st = wl_pkg::C_FSTWT;
                    nxt_q.cnt = wl_pkg::FIRST_CYC;
                end
            end
            wl_pkg::C_FSTWT:
            begin
                if (q_ff.cnt != 8'h00)
                    nxt_q.cnt = q_ff.cnt - 8'h01;
                else if (q_ff.ckCnt == PW'(PER - 1))
                begin
                    nxt_q.rc = '0;
                    nxt_q.st = wl_pkg::C_ROUND;
                end
            end
            wl_pkg::C_ROUND:
            begin
                // First half stays low, one rising edge in second half
                nxt_q.rc = q_ff.rc + 1'b1;
                for (int l = 0; l < LANES; l++)
                begin
                    rise = (PW+2)'(PER) + (PW+2)'(q_ff.dly[l*PW +: PW]);
                    nxt_q.stb[l] = (nxt_q.rc >= rise)
                                   && (nxt_q.rc < rise + (PW+2)'(HI_W));
                end
                // Round runs past the latest pulse so no pulse is cut short
                if (q_ff.rc == (PW+2)'(2 * PER + HI_W - 1))
                begin
                    nxt_q.st = wl_pkg::C_FBWT;
                    nxt_q.cnt = wl_pkg::FBO_CYC + 8'h01;
                end
            end
            wl_pkg::C_FBWT:
            begin
                nxt_q.cnt = q_ff.cnt - 8'h01;
                if (q_ff.cnt == 8'h01)
                begin
                    for (int l = 0; l < LANES; l++)
                    begin
                        fb = lnk.dq[l*LW];
                        nxt_q.prev[l] = fb;
                        if (!q_ff.lock[l])
                        begin
                            if (q_ff.seen && !q_ff.prev[l] && fb)
                                nxt_q.lock[l] = 1'b1;
                            else if (q_ff.dly[l*PW +: PW] == PW'(PER - 1))
                                nxt_q.fail = 1'b1;
                            else
                                nxt_q.dly[l*PW +: PW] = q_ff.dly[l*PW +: PW] + 1'b1;
                        end
                    end
                    nxt_q.seen = 1'b1;
                    nxt_q.st = wl_pkg::C_FSTWT;
                    nxt_q.cnt = 8'h00;
                    if (&nxt_q.lock || nxt_q.fail)
                    begin
                        nxt_q.stbOe_n = 1'b1;
                        nxt_q.termination_control_pin = 1'b0;
                        nxt_q.st = wl_pkg::C_EXODT;
                        nxt_q.cnt = wl_pkg::ODT_OFF_CYC;
                    end
                end
            end
            wl_pkg::C_EXODT:
            begin
                nxt_q.cnt = q_ff.cnt - 8'h01;
                if (q_ff.cnt == 8'h01)
                    nxt_q.st = wl_pkg::C_EXMR;
            end
            wl_pkg::C_EXMR:
            begin
                nxt_q.cmd = wl_pkg::CMD_MODE;
                nxt_q.addr[wl_pkg::BIT_LVL] = 1'b0;
                nxt_q.st = wl_pkg::C_EXWT;
                nxt_q.cnt = wl_pkg::MOD_CYC;
            end
            wl_pkg::C_EXWT:
            begin
                nxt_q.cnt = q_ff.cnt - 8'h01;
                if (q_ff.cnt == 8'h01)
                begin
                    nxt_q.st = wl_pkg::C_IDLE;
                    nxt_q.busy = 1'b0;
                    nxt_q.done = !q_ff.fail;
                end
            end
            default:
                nxt_q.st = wl_pkg::C_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            q_ff <= '{st: wl_pkg::C_IDLE, stbOe_n: 1'b1, awready: 1'b1, wready: 1'b1,
                      arready: 1'b1, default: '0};
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    assign lnk.cmd = q_ff.cmd;
    assign lnk.cmdAddr = q_ff.addr;
    assign lnk.termination_control_pin = q_ff.termination_control_pin;
    assign lnk.memCk = q_ff.ckCnt[PW-1];
    assign lnk.ctlStb = q_ff.stb;
    assign lnk.ctlStbOe_n = q_ff.stbOe_n;
    assign lnk.ctlDq = '0;
    assign lnk.ctlDqOe_n = 1'b1;
    assign awready = q_ff.awready;
    assign wready = q_ff.wready;
    assign bvalid = q_ff.bvalid;
    assign bresp = q_ff.bresp;
    assign arready = q_ff.arready;
    assign rvalid = q_ff.rvalid;
    assign rdata = q_ff.rdata;
    assign rresp = q_ff.rresp;
endmodule : wl_ctl_end
`default_nettype wire

// ---- wl_link_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module wl_link_asserts (
    input  wire logic        ref_clk,      // Command clock
    input  wire logic        srst,         // Sync reset
    input  wire logic [1:0]  cmd,          // Link command
    input  wire logic [12:0] cmdAddr,      // Mode write bits
    input  wire logic        ctlStbOe_n,   // Strobe drive enable
    input  wire logic        devDqOe_n,    // Feedback drive enable
    input  wire logic [1:0]  stb,          // Resolved strobes
    input  wire logic [15:0] dq,           // Resolved data
    input  wire logic        levelActive,  // Leveling on
    input  wire logic        strobeTermOn, // Strobe termination
    input  wire logic        dqTermOn,     // Data termination
    input  wire logic        fbValid,      // Feedback valid
    input  wire logic        cmdFault      // Illegal command
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence s_entry;
        cmd == wl_pkg::CMD_MODE && cmdAddr[wl_pkg::BIT_LVL];
    endsequence
    sequence s_exit;
        cmd == wl_pkg::CMD_MODE && !cmdAddr[wl_pkg::BIT_LVL];
    endsequence
    property p_enter;
        s_entry |-> ##[1:2] levelActive;
    endproperty
    a_enter: assert property (p_enter) else $error("leveling not entered");
    property p_leave;
        levelActive ##0 s_exit |-> ##[1:30] (!levelActive && devDqOe_n);
    endproperty
    a_leave: assert property (p_leave) else $error("leveling not left");
    property p_dq_term;
        levelActive |-> !dqTermOn;
    endproperty
    a_dq_term: assert property (p_dq_term) else $error("data termination on");
    property p_stb_term;
        levelActive && $fell(ctlStbOe_n) |-> strobeTermOn;
    endproperty
    a_stb_term: assert property (p_stb_term) else $error("strobe not terminated");
    property p_lane;
        fbValid && !devDqOe_n |-> (dq[7:0] == 8'h00 || dq[7:0] == 8'hff)
            && (dq[15:8] == 8'h00 || dq[15:8] == 8'hff);
    endproperty
    a_lane: assert property (p_lane) else $error("lane bits differ");
    // Three quiet strobe samples leave room for the feedback pipeline to settle
    property p_hold;
        fbValid && !devDqOe_n && !$past(devDqOe_n) && !$past(stb[0])
            && !$past(stb[0], 2) && !$past(stb[0], 3) |-> $stable(dq[7:0]);
    endproperty
    a_hold: assert property (p_hold) else $error("feedback not held");
    property p_exit_quiet;
        s_exit |=> (cmd == wl_pkg::CMD_DESEL) [*7];
    endproperty
    a_exit_quiet: assert property (p_exit_quiet) else $error("command too soon");
    property p_legal;
        levelActive |-> cmd != wl_pkg::CMD_OTHER && !cmdFault;
    endproperty
    a_legal: assert property (p_legal) else $error("illegal command");
endmodule : wl_link_asserts
`default_nettype wire

// ---- ddr4_write_leveling_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module ddr4_write_leveling_tb;
    logic        ref_clk, srst, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        levelActive, strobeTermOn, dqTermOn, fbValid, cmdFault, termFault;
    logic [2:0]  parkCode;
    logic [7:0]  awaddr, araddr;
    logic [3:0]  wstrb;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, r;
    int          miscompares, checks;
    wl_link_if i_wl_link_if ();
    wl_ctl_end i_wl_ctl_end (.ref_clk(ref_clk), .srst(srst), .lnk(i_wl_link_if),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));
    wl_dev_end i_wl_dev_end (.ref_clk(ref_clk), .srst(srst), .lnk(i_wl_link_if),
        .parkCode(parkCode), .levelActive(levelActive), .strobeTermOn(strobeTermOn),
        .dqTermOn(dqTermOn), .fbValid(fbValid), .cmdFault(cmdFault), .termFault(termFault));
    wl_link_asserts i_wl_link_asserts (.ref_clk(ref_clk), .srst(srst),
        .cmd(i_wl_link_if.cmd), .cmdAddr(i_wl_link_if.cmdAddr),
        .ctlStbOe_n(i_wl_link_if.ctlStbOe_n), .devDqOe_n(i_wl_link_if.devDqOe_n),
        .stb(i_wl_link_if.stb), .dq(i_wl_link_if.dq), .levelActive(levelActive),
        .strobeTermOn(strobeTermOn), .dqTermOn(dqTermOn), .fbValid(fbValid),
        .cmdFault(cmdFault));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        if (miscompares == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er});
        @(posedge ref_clk);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge ref_clk);
    endtask : axi_rd
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        complete_run();
    end
    initial
    begin
        {srst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {parkCode, awaddr, araddr, wstrb, wdata} = '0;
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        wstrb <= 4'hf;
        repeat (2) @(posedge ref_clk);
        axi_rd(8'h0c);
        check(d, 32'h0);
        check({30'h0, r}, {30'h0, wl_pkg::RESP_SLVERR});
        axi_wr(8'h10, 32'h1, wl_pkg::RESP_SLVERR);
        axi_rd(wl_pkg::REG_STATUS);
        check(d, 32'h0);
        // Second pass adds park termination so both pin levels terminate the strobes
        for (int i = 0; i < 2; i++)
        begin
            parkCode <= (i == 0) ? 3'h0 : 3'h2;
            axi_wr(wl_pkg::REG_CTRL, (i == 0) ? 32'h7 : 32'hb, wl_pkg::RESP_OKAY);
            axi_rd(wl_pkg::REG_CTRL);
            check(d, (i == 0) ? 32'h6 : 32'ha);
            axi_rd(wl_pkg::REG_STATUS);
            check(d & 32'h1, 32'h1);
            check({31'h0, levelActive}, 32'h1);
            check({31'h0, termFault}, 32'h1);
            check({31'h0, dqTermOn}, 32'h0);
            do
                axi_rd(wl_pkg::REG_STATUS);
            while (d[1] !== 1'b1);
            check(d, 32'h302);
            check({31'h0, levelActive}, 32'h0);
            check({31'h0, termFault}, 32'h0);
            check({31'h0, fbValid}, 32'h0);
            axi_rd(wl_pkg::REG_RESULT);
            check(d, 32'h24);
            check({31'h0, cmdFault}, 32'h0);
        end
        complete_run();
    end
endmodule : ddr4_write_leveling_tb
`default_nettype wire
